// *** tb/accel_fifo_status_readout_test.sv ***
`include "afsr_map.vh"
module accel_fifo_status_readout_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TDIV = 2;
	localparam int PER = 128 * TDIV;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [19:0] ax = 20'h8_1234;
	logic [19:0] ay = 20'h1_5678;
	logic [19:0] az = 20'hf_9abc;
	logic [11:0] temp = 12'ha5c;
	logic nvm = 1'b0;
	logic start, rd, wr, irq_a, irq_b, srdy;
	logic [9:0] xa, addr;
	logic [7:0] wd, rdata, d;
	logic [1:0] pins;
	logic [191:0] img;
	int fails = 0;
	int checks_done = 0;
	int cycles = 0;
	int t0;
	always #5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles++;
		// The full sequence needs about 11k cycles
		if (cycles == 30000) begin
			fails++;
			conclude();
		end
	end
	afsr_host host (.clk_in(clk_in), .rdata_in(rdata), .start_out(start), .addr_out(xa), .rd_out(rd), .wr_out(wr),
		.wdata_out(wd));
	afsr_core #(.TICK_DIV(TDIV)) uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .accel_x_in(ax), .accel_y_in(ay),
		.accel_z_in(az), .temp_in(temp), .nvm_ctrl_busy_flag_in(nvm), .xfer_start_in(start), .xfer_addr_in(xa),
		.byte_rd_in(rd), .byte_wr_in(wr), .byte_wdata_in(wd), .byte_rdata_out(rdata), .xfer_addr_out(addr),
		.irq_out_a(irq_a), .irq_out_b(irq_b), .sample_ready_pin_out(srdy));
	task automatic check(input string what, input logic [23:0] e, input logic [23:0] s);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", what, e, s);
		end
	endtask
	task automatic rd_reg(input logic [9:0] a, output logic [7:0] v);
		host.begin_xfer(a);
		host.get(v);
	endtask
	// Waits for a fresh rise, so a pin still high from before is skipped
	task automatic wait_ready;
		int n;
		n = 0;
		while (srdy === 1'b1 && n < 4 * PER) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		while (srdy !== 1'b1 && n < 8 * PER) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		check("ready pin", 1'b1, srdy);
	endtask
	task automatic conclude;
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		// Axis registers carry the x marker too; two empty queue words close the image
		img = {ax, 4'h1, ay, 4'h0, az, 4'h0, ax, 4'h1, ay, 4'h0, az, 4'h0, 24'h00_0002, 24'h00_0002};
		repeat (4) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		host.begin_xfer(`AFSR_A_ACT_HI);
		host.put(8'h00);
		host.put(8'h01);
		// Axis registers, then the queue behind the held address, then two empty words
		wait_ready();
		host.begin_xfer(`AFSR_A_ACCEL_X_REGS);
		for (int i = 0; i < 24; i++) begin
			host.get(d);
			check("data byte", img[191 - 8 * i -: 8], d);
		end
		check("address", `AFSR_A_FIFO, addr);
		check("ready pin", 1'b0, srdy);
		host.begin_xfer(`AFSR_A_TEMP_HI);
		host.get(d);
		check("temp high", {4'h0, temp[11:8]}, d);
		host.get(d);
		check("temp low", temp[7:0], d);
		wait_ready();
		rd_reg(`AFSR_A_STATUS, d);
		check("status", 8'h09, d & 8'h09);
		repeat (6 * TDIV) @(posedge clk_in);
		rd_reg(`AFSR_A_STATUS, d);
		check("status", 8'h00, d & 8'h09);
		wait_ready();
		rd_reg(`AFSR_A_STATUS, d);
		check("status", 8'h08, d & 8'h08);
		repeat (34) wait_ready();
		rd_reg(`AFSR_A_STATUS, d);
		check("status", 8'h06, d & 8'h06);
		rd_reg(`AFSR_A_STATUS, d);
		check("status", 8'h02, d & 8'h06);
		rd_reg(`AFSR_A_FIFO, d);
		rd_reg(`AFSR_A_STATUS, d);
		check("status", 8'h00, d & 8'h02);
		host.begin_xfer(`AFSR_A_INT_MAP);
		host.put(8'h01);
		wait_ready();
		repeat (2) @(posedge clk_in);
		#1;
		check("irq pins differ", 1'b1, irq_a ^ irq_b);
		rd_reg(`AFSR_A_RANGE, d);
		pins = ~{irq_a, irq_b};
		host.begin_xfer(`AFSR_A_RANGE);
		host.put(d ^ 8'h40);
		repeat (2) @(posedge clk_in);
		#1;
		check("irq pins", pins, {irq_a, irq_b});
		check("ready pin", 1'b1, srdy);
		@(posedge clk_in);
		nvm <= 1'b1;
		repeat (8) @(posedge clk_in);
		#1;
		check("irq pins differ", 1'b0, irq_a ^ irq_b);
		@(posedge clk_in);
		nvm <= 1'b0;
		repeat (8) @(posedge clk_in);
		rd_reg(`AFSR_A_STATUS, d);
		check("status", 8'h10, d & 8'h10);
		rd_reg(`AFSR_A_STATUS, d);
		check("status", 8'h00, d & 8'h10);
		host.begin_xfer(10'h3fe);
		host.get(d);
		host.get(d);
		check("address", `AFSR_A_TOP, addr);
		check("unmapped byte", 8'h00, d);
		host.begin_xfer(`AFSR_A_SYNC);
		host.put(8'hff);
		rd_reg(`AFSR_A_SYNC, d);
		check("sync bits", 8'h07, d);
		host.begin_xfer(`AFSR_A_RATE);
		host.put(8'h01);
		repeat (2) wait_ready();
		t0 = cycles;
		repeat (PER + 44) @(posedge clk_in);
		#1;
		check("ready pin", 1'b0, srdy);
		wait_ready();
		check("sample period", 2 * PER, cycles - t0);
		conclude();
	end
endmodule

// *** tb/afsr_core_monitor.sv ***
`include "afsr_map.vh"
module afsr_core_monitor #(
	parameter DEPTH = 96,
	parameter TICK_DIV = 195
) (
	input wire clk_in,
	input wire sys_rst_in,
	input wire nvm_ctrl_busy_flag_in,
	input wire xfer_start_in,
	input wire byte_rd_in,
	input wire byte_wr_in,
	input wire [7:0] byte_rdata_out,
	input wire [9:0] xfer_addr_out,
	input wire irq_out_a,
	input wire irq_out_b,
	input wire sample_ready_pin_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// A start outranks a byte strobe in the same cycle
	wire rd = byte_rd_in & ~xfer_start_in;
	wire acc = (byte_rd_in | byte_wr_in) & ~xfer_start_in;
	wire [9:0] a = xfer_addr_out;
	property p_adv;
		acc && a != `AFSR_A_FIFO && a != `AFSR_A_TOP |=> a == $past(a) + 10'h001;
	endproperty
	a_adv: assert property (p_adv) else $error("address did not advance");
	property p_top;
		acc && a == `AFSR_A_TOP |=> a == `AFSR_A_TOP;
	endproperty
	a_top: assert property (p_top) else $error("address left the top");
	property p_fifo_hold;
		acc && a == `AFSR_A_FIFO |=> a == `AFSR_A_FIFO;
	endproperty
	a_fifo_hold: assert property (p_fifo_hold) else $error("address left the queue");
	property p_ready_clr;
		rd && a >= `AFSR_A_ACCEL_X_REGS && a <= `AFSR_A_FIFO |=> !sample_ready_pin_out;
	endproperty
	a_ready_clr: assert property (p_ready_clr) else $error("ready pin kept after data read");
	property p_status;
		rd && a == `AFSR_A_STATUS |=> byte_rdata_out[7:5] == 3'b000;
	endproperty
	a_status: assert property (p_status) else $error("status has extra bits");
	property p_temp;
		rd && a == `AFSR_A_TEMP_HI |=> byte_rdata_out[7:4] == 4'h0;
	endproperty
	a_temp: assert property (p_temp) else $error("temperature wider than 12 bits");
	property p_nvm;
		nvm_ctrl_busy_flag_in [*6] |=> irq_out_a == irq_out_b;
	endproperty
	a_nvm: assert property (p_nvm) else $error("interrupt while memory busy");
	property p_pol;
		byte_wr_in && !xfer_start_in && a == `AFSR_A_RANGE |=> $stable(sample_ready_pin_out);
	endproperty
	a_pol: assert property (p_pol) else $error("ready pin moved on range write");
endmodule
bind afsr_core afsr_core_monitor #(.DEPTH(DEPTH), .TICK_DIV(TICK_DIV)) mon (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
	.nvm_ctrl_busy_flag_in(nvm_ctrl_busy_flag_in), .xfer_start_in(xfer_start_in), .byte_rd_in(byte_rd_in), .byte_wr_in(byte_wr_in),
	.byte_rdata_out(byte_rdata_out), .xfer_addr_out(xfer_addr_out), .irq_out_a(irq_out_a), .irq_out_b(irq_out_b),
	.sample_ready_pin_out(sample_ready_pin_out));

// *** tb/afsr_host.sv ***
module afsr_host (
	input wire clk_in,
	input wire [7:0] rdata_in,
	output logic start_out = 1'b0,
	output logic [9:0] addr_out = 10'h000,
	output logic rd_out = 1'b0,
	output logic wr_out = 1'b0,
	output logic [7:0] wdata_out = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	// Spent address and data are inverted so a stale value never looks valid
	task automatic begin_xfer(input logic [9:0] a);
		@(posedge clk_in);
		start_out <= 1'b1;
		addr_out <= a;
		@(posedge clk_in);
		start_out <= 1'b0;
		addr_out <= ~a;
	endtask
	task automatic get(output logic [7:0] d);
		@(posedge clk_in);
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		#1;
		d = rdata_in;
	endtask
	task automatic put(input logic [7:0] v);
		@(posedge clk_in);
		wr_out <= 1'b1;
		wdata_out <= v;
		@(posedge clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~v;
	endtask
endmodule

// *** verilog/afsr_core.v ***
// Functional notes
// - Axis bytes left justified, MSB first
// - Temperature 12 bits, unbuffered, two bytes
// - Address advances per byte, stops at top
// - Address holds once at FIFO address
// - Full FIFO drops oldest, never refuses
// - Three bytes per entry from one measurement
// - 96 entries of 20 data bits plus marker
// - Pop on first byte, then every third
// - Read word: data, 00, empty, x marker
// - Axis registers read newest set via z pointer
// - Five status bits, four mappable, selectable polarity
// - Status read clears unless condition persists
// - New-sample bit sets only on newer data
// - New-sample clear delayed four internal ticks
// - Ready pin clears on axis or FIFO reads or midway
// - Ready pin always active high
// - Full sets at threshold, clears below it
// - Overrun sets only on lost data
// - Activity over threshold for run length
// - Memory busy gates interrupts, status read clears after idle
// - Default mode timed by internal rate register
`include "afsr_map.vh"
module afsr_core #(
	parameter DEPTH = `AFSR_FIFO_DEPTH,
	parameter TICK_DIV = `AFSR_TICK_DIV
) (
	// Clock and reset
	input wire clk_in,
	input wire sys_rst_in,
	// Measurement results from the filter chain
	input wire [19:0] accel_x_in,
	input wire [19:0] accel_y_in,
	input wire [19:0] accel_z_in,
	input wire [11:0] temp_in,
	// Memory controller state, asynchronous
	input wire nvm_ctrl_busy_flag_in,
	// Byte access from the serial front end
	input wire xfer_start_in,
	input wire [9:0] xfer_addr_in,
	input wire byte_rd_in,
	input wire byte_wr_in,
	input wire [7:0] byte_wdata_in,
	output reg [7:0] byte_rdata_out,
	output wire [9:0] xfer_addr_out,
	// Pins
	output reg irq_out_a,
	output reg irq_out_b,
	output reg sample_ready_pin_out
);
	localparam S_IDLE = 4'b0001;
	localparam S_WX = 4'b0010;
	localparam S_WY = 4'b0100;
	localparam S_WZ = 4'b1000;

	reg [20:0] mem_r [0:DEPTH-1];
	reg [6:0] wptr_r, rptr_r, zptr_r, count_r;
	reg [3:0] wst_r;
	reg [19:0] lat_x_r, lat_y_r, lat_z_r;
	reg [9:0] addr_r;
	reg [1:0] fphase_r;
	reg [23:0] fword_r;
	reg [7:0] act_hi_r, act_lo_r, act_cnt_r, rate_r, thr_r, map_r, sync_r, range_r;
	reg [7:0] act_run_r;
	reg [4:0] status_r;
	reg sample_ready_pin_clr_pend_r, sample_ready_pin_newer_r;
	reg [2:0] sample_ready_pin_clr_cnt_r;
	reg [7:0] div_r;
	reg tick_r;
	reg [17:0] odr_cnt_r;
	reg nvm_m_r, nvm_s_r;
	reg [7:0] rdata_nxt;
	reg [20:0] axis_ent;
	reg [6:0] axis_idx;
	integer i;

	wire [17:0] odr_period = (18'd`AFSR_ODR_BASE) << rate_r[3:0];
	wire sample_go = tick_r && (odr_cnt_r == odr_period - 18'd1);
	wire midway = tick_r && (odr_cnt_r == (odr_period >> 1));
	wire in_fifo = (addr_r == `AFSR_A_FIFO);
	wire in_axis = (addr_r >= `AFSR_A_ACCEL_X_REGS) && (addr_r <= `AFSR_A_ACCEL_Z_REGS_END);
	// A start outranks a byte strobe in the same cycle
	wire rd_status = byte_rd_in && !xfer_start_in && (addr_r == `AFSR_A_STATUS);
	wire fifo_pop = byte_rd_in && !xfer_start_in && in_fifo && (fphase_r == 2'd0) && (count_r != 7'd0);
	wire fifo_wr = (wst_r != S_IDLE);
	wire fifo_full_now = (count_r == DEPTH[6:0]);
	wire fifo_drop = fifo_wr && fifo_full_now && !fifo_pop;
	wire [20:0] wr_ent = (wst_r == S_WX) ? {lat_x_r, 1'b1} :
		(wst_r == S_WY) ? {lat_y_r, 1'b0} : {lat_z_r, 1'b0};
	wire meas_done = (wst_r == S_WZ);
	wire pol_low = range_r[`AFSR_RANGE_POL];

	assign xfer_addr_out = addr_r;

	function [6:0] inc96;
		input [6:0] p;
		begin
			inc96 = (p == DEPTH[6:0] - 7'd1) ? 7'd0 : p + 7'd1;
		end
	endfunction

	function [19:0] mag;
		input [19:0] v;
		begin
			mag = v[19] ? (~v + 20'd1) : v;
		end
	endfunction

	// Internal 512 kHz tick and output data rate counter
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			div_r <= 8'h00;
			tick_r <= 1'b0;
			odr_cnt_r <= 18'd0;
		end else begin
			tick_r <= (div_r == TICK_DIV[7:0] - 8'd1);
			div_r <= (div_r == TICK_DIV[7:0] - 8'd1) ? 8'h00 : div_r + 8'h01;
			if (tick_r) begin
				odr_cnt_r <= (odr_cnt_r >= odr_period - 18'd1) ? 18'd0 : odr_cnt_r + 18'd1;
			end
		end
	end

	// Memory busy pin synchroniser
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			nvm_m_r <= 1'b0;
			nvm_s_r <= 1'b0;
		end else begin
			nvm_m_r <= nvm_ctrl_busy_flag_in;
			nvm_s_r <= nvm_m_r;
		end
	end

	// Sample capture and x, y, z write sequence
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			wst_r <= S_IDLE;
			lat_x_r <= 20'h0_0000;
			lat_y_r <= 20'h0_0000;
			lat_z_r <= 20'h0_0000;
		end else begin
			case (wst_r)
			S_IDLE: begin
				if (sample_go) begin
					lat_x_r <= accel_x_in;
					lat_y_r <= accel_y_in;
					lat_z_r <= accel_z_in;
					wst_r <= S_WX;
				end
			end
			S_WX: wst_r <= S_WY;
			S_WY: wst_r <= S_WZ;
			S_WZ: wst_r <= S_IDLE;
			default: wst_r <= S_IDLE;
			endcase
		end
	end

	// Entry storage
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_r[i] <= 21'h00_0000;
			end
		end else if (fifo_wr) begin
			mem_r[wptr_r] <= wr_ent;
		end
	end

	// Pointers and fill level
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			wptr_r <= 7'd0;
			rptr_r <= 7'd0;
			zptr_r <= 7'd0;
			count_r <= 7'd0;
		end else begin
			if (fifo_wr) begin
				wptr_r <= inc96(wptr_r);
			end
			if (meas_done) begin
				zptr_r <= wptr_r;
			end
			if (fifo_pop || fifo_drop) begin
				rptr_r <= inc96(rptr_r);
			end
			if (fifo_wr && !fifo_pop && !fifo_full_now) begin
				count_r <= count_r + 7'd1;
			end else if (!fifo_wr && fifo_pop) begin
				count_r <= count_r - 7'd1;
			end
		end
	end

	// Address walk and FIFO word hold
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			addr_r <= 10'h000;
			fphase_r <= 2'd0;
			fword_r <= 24'h00_0000;
		end else if (xfer_start_in) begin
			addr_r <= xfer_addr_in;
			fphase_r <= 2'd0;
		end else if (byte_rd_in || byte_wr_in) begin
			if (!in_fifo && addr_r != `AFSR_A_TOP) begin
				addr_r <= addr_r + 10'h001;
			end
			if (byte_rd_in && in_fifo) begin
				fphase_r <= (fphase_r == 2'd2) ? 2'd0 : fphase_r + 2'd1;
				if (fphase_r == 2'd0) begin
					if (count_r != 7'd0) begin
						fword_r <= {mem_r[rptr_r][20:1], 2'b00, 1'b0, mem_r[rptr_r][0]};
					end else begin
						fword_r <= {20'h0_0000, 2'b00, 1'b1, 1'b0};
					end
				end
			end
		end
	end

	// Newest set entry for the axis registers
	always @* begin
		axis_idx = zptr_r;
		if (addr_r < `AFSR_A_ACCEL_X_REGS + 10'h003) begin
			axis_idx = (zptr_r < 7'd2) ? zptr_r + DEPTH[6:0] - 7'd2 : zptr_r - 7'd2;
		end else if (addr_r < `AFSR_A_ACCEL_X_REGS + 10'h006) begin
			axis_idx = (zptr_r < 7'd1) ? zptr_r + DEPTH[6:0] - 7'd1 : zptr_r - 7'd1;
		end
		axis_ent = mem_r[axis_idx];
	end

	// Read data, registered
	always @* begin
		rdata_nxt = 8'h00;
		if (addr_r == `AFSR_A_STATUS) begin
			rdata_nxt = {3'b000, status_r};
		end else if (addr_r == `AFSR_A_TEMP_HI) begin
			rdata_nxt = {4'h0, temp_in[11:8]};
		end else if (addr_r == `AFSR_A_TEMP_LO) begin
			rdata_nxt = temp_in[7:0];
		end else if (in_axis) begin
			if ((addr_r - `AFSR_A_ACCEL_X_REGS) % 10'd3 == 10'd0) begin
				rdata_nxt = axis_ent[20:13];
			end else if ((addr_r - `AFSR_A_ACCEL_X_REGS) % 10'd3 == 10'd1) begin
				rdata_nxt = axis_ent[12:5];
			end else begin
				rdata_nxt = {axis_ent[4:1], 2'b00, 1'b0, axis_ent[0]};
			end
		end else if (in_fifo) begin
			if (fphase_r == 2'd0) begin
				rdata_nxt = (count_r != 7'd0) ? mem_r[rptr_r][20:13] : 8'h00;
			end else if (fphase_r == 2'd1) begin
				rdata_nxt = fword_r[15:8];
			end else begin
				rdata_nxt = fword_r[7:0];
			end
		end else if (addr_r == `AFSR_A_ACT_HI) begin
			rdata_nxt = act_hi_r;
		end else if (addr_r == `AFSR_A_ACT_LO) begin
			rdata_nxt = act_lo_r;
		end else if (addr_r == `AFSR_A_ACT_CNT) begin
			rdata_nxt = act_cnt_r;
		end else if (addr_r == `AFSR_A_RATE) begin
			rdata_nxt = rate_r;
		end else if (addr_r == `AFSR_A_FIFO_THR) begin
			rdata_nxt = thr_r;
		end else if (addr_r == `AFSR_A_INT_MAP) begin
			rdata_nxt = map_r;
		end else if (addr_r == `AFSR_A_SYNC) begin
			rdata_nxt = sync_r;
		end else if (addr_r == `AFSR_A_RANGE) begin
			rdata_nxt = range_r;
		end
	end

	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			byte_rdata_out <= 8'h00;
		end else if (byte_rd_in && !xfer_start_in) begin
			byte_rdata_out <= rdata_nxt;
		end
	end

	// Configuration writes
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			act_hi_r <= 8'h00;
			act_lo_r <= 8'h00;
			act_cnt_r <= `AFSR_RST_ACT_CNT;
			rate_r <= `AFSR_RST_RATE;
			thr_r <= `AFSR_RST_THR;
			map_r <= 8'h00;
			sync_r <= 8'h00;
			range_r <= `AFSR_RST_RANGE;
		end else if (byte_wr_in && !xfer_start_in) begin
			if (addr_r == `AFSR_A_ACT_HI) begin
				act_hi_r <= byte_wdata_in;
			end else if (addr_r == `AFSR_A_ACT_LO) begin
				act_lo_r <= byte_wdata_in;
			end else if (addr_r == `AFSR_A_ACT_CNT) begin
				act_cnt_r <= byte_wdata_in;
			end else if (addr_r == `AFSR_A_RATE) begin
				rate_r <= (byte_wdata_in[3:0] > 4'hA) ? 8'h0A : {4'h0, byte_wdata_in[3:0]};
			end else if (addr_r == `AFSR_A_FIFO_THR) begin
				thr_r <= (byte_wdata_in > 8'h60) ? 8'h60 : byte_wdata_in;
			end else if (addr_r == `AFSR_A_INT_MAP) begin
				map_r <= byte_wdata_in;
			end else if (addr_r == `AFSR_A_SYNC) begin
				// Only the internally timed mode is built; the bits are kept for software
				sync_r <= {5'b00000, byte_wdata_in[2:0]};
			end else if (addr_r == `AFSR_A_RANGE) begin
				range_r <= byte_wdata_in;
			end
		end
	end

	// Activity run counter, updated once per complete set
	wire [19:0] act_lvl = {act_hi_r, act_lo_r, 4'h0};
	wire over = (mag(lat_x_r) > act_lvl) || (mag(lat_y_r) > act_lvl) || (mag(lat_z_r) > act_lvl);
	// Nine bits so a saturated run length still counts as a hit
	wire act_hit = meas_done && over && ({1'b0, act_run_r} + 9'd1 >= {1'b0, act_cnt_r});
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			act_run_r <= 8'h00;
		end else if (meas_done) begin
			if (!over) begin
				act_run_r <= 8'h00;
			end else if (act_run_r != 8'hFF) begin
				act_run_r <= act_run_r + 8'd1;
			end
		end
	end

	// Status flags; a set in the clearing cycle always wins
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			status_r <= 5'b00000;
			sample_ready_pin_clr_pend_r <= 1'b0;
			sample_ready_pin_newer_r <= 1'b0;
			sample_ready_pin_clr_cnt_r <= 3'd0;
		end else begin
			// Clear is deferred so a sample landing mid-read is not swallowed
			if (rd_status) begin
				sample_ready_pin_clr_pend_r <= 1'b1;
				sample_ready_pin_clr_cnt_r <= 3'd0;
				sample_ready_pin_newer_r <= 1'b0;
			end else if (sample_ready_pin_clr_pend_r && tick_r) begin
				if (sample_ready_pin_clr_cnt_r == `AFSR_SAMPLE_READY_PIN_CLR_TICKS - 1) begin
					sample_ready_pin_clr_pend_r <= 1'b0;
				end
				sample_ready_pin_clr_cnt_r <= sample_ready_pin_clr_cnt_r + 3'd1;
			end
			if (meas_done && (sample_ready_pin_clr_pend_r || rd_status)) begin
				sample_ready_pin_newer_r <= 1'b1;
			end
			if (meas_done) begin
				status_r[`AFSR_ST_SAMPLE_READY_PIN] <= 1'b1;
			end else if (sample_ready_pin_clr_pend_r && tick_r && sample_ready_pin_clr_cnt_r == `AFSR_SAMPLE_READY_PIN_CLR_TICKS - 1 && !sample_ready_pin_newer_r) begin
				status_r[`AFSR_ST_SAMPLE_READY_PIN] <= 1'b0;
			end
			if ({1'b0, count_r} == thr_r) begin
				status_r[`AFSR_ST_FULL] <= 1'b1;
			end else if ({1'b0, count_r} < thr_r) begin
				status_r[`AFSR_ST_FULL] <= 1'b0;
			end
			if (fifo_drop) begin
				status_r[`AFSR_ST_OVR] <= 1'b1;
			end else if (rd_status) begin
				status_r[`AFSR_ST_OVR] <= 1'b0;
			end
			if (act_hit) begin
				status_r[`AFSR_ST_ACT] <= 1'b1;
			end else if (rd_status) begin
				status_r[`AFSR_ST_ACT] <= 1'b0;
			end
			if (nvm_s_r) begin
				status_r[`AFSR_ST_NVM] <= 1'b1;
			end else if (rd_status) begin
				status_r[`AFSR_ST_NVM] <= 1'b0;
			end
		end
	end

	// Interrupt pins and sample-ready pin
	wire int_ok = !status_r[`AFSR_ST_NVM];
	wire act_a = int_ok && |(status_r[3:0] & map_r[3:0]);
	wire act_b = int_ok && |(status_r[3:0] & map_r[7:4]);
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			irq_out_a <= 1'b0;
			irq_out_b <= 1'b0;
			sample_ready_pin_out <= 1'b0;
		end else begin
			irq_out_a <= act_a ^ pol_low;
			irq_out_b <= act_b ^ pol_low;
			if (meas_done) begin
				sample_ready_pin_out <= 1'b1;
			end else if ((byte_rd_in && !xfer_start_in && (in_fifo || in_axis)) || midway) begin
				sample_ready_pin_out <= 1'b0;
			end
		end
	end
endmodule

// *** verilog/afsr_map.vh ***
`ifndef AFSR_MAP_VH
`define AFSR_MAP_VH
// Register byte addresses
`define AFSR_A_STATUS 10'h004
`define AFSR_A_TEMP_HI 10'h006
`define AFSR_A_TEMP_LO 10'h007
`define AFSR_A_ACCEL_X_REGS 10'h008
`define AFSR_A_ACCEL_Z_REGS_END 10'h010
`define AFSR_A_FIFO 10'h011
`define AFSR_A_ACT_HI 10'h025
`define AFSR_A_ACT_LO 10'h026
`define AFSR_A_ACT_CNT 10'h027
`define AFSR_A_RATE 10'h028
`define AFSR_A_FIFO_THR 10'h029
`define AFSR_A_INT_MAP 10'h02A
`define AFSR_A_SYNC 10'h02B
`define AFSR_A_RANGE 10'h02C
`define AFSR_A_TOP 10'h3FF
// Status bit positions
`define AFSR_ST_SAMPLE_READY_PIN 0
`define AFSR_ST_FULL 1
`define AFSR_ST_OVR 2
`define AFSR_ST_ACT 3
`define AFSR_ST_NVM 4
// Field positions
`define AFSR_RANGE_POL 6
`define AFSR_SYNC_EXTCLK 2
// Reset values
`define AFSR_RST_RATE 8'h00
`define AFSR_RST_THR 8'h60
`define AFSR_RST_RANGE 8'h81
`define AFSR_RST_ACT_CNT 8'h01
// Timing: 512 kHz internal tick from a 100 MHz clock
`define AFSR_CLK_HZ 100000000
`define AFSR_TICK_HZ 512000
`define AFSR_TICK_DIV (`AFSR_CLK_HZ / `AFSR_TICK_HZ)
`define AFSR_ODR_BASE 128
`define AFSR_SAMPLE_READY_PIN_CLR_TICKS 4
`define AFSR_FIFO_DEPTH 96
`endif
